// ==== core/fslc_link_config.sv ====
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
// How it works
// - Speed value 0..4 decodes to 156k, 625k, 2.5M, 5M, 10M bit/s.
// - Changed speed flickers error lamp; old speed stays until reset or power-up.
// - Link data refresh runs continuously, period 1.1 ms to 141 ms per station.
// - Extension 0,1 single station ver 1; 12,14,18 double, quad, octuple ver 2.
// - Extension change takes effect only after a device reset.
// - Version-2 occupancy only with a version-2 master; else single only.
// - Network error reset acts only while a protective alarm is active.
// - Network history clear erases the last eight stored alarms.
// - Station number 1 to 64, default 1, one remote device station.
module fslc_link_config #(
   parameter int refresh_timeout = fslc_pkg::refresh_max_cyc,
   parameter int flicker_period  = fslc_pkg::flicker_cyc
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [11:0]           paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  reset_input_terminal,
   input  wire logic                  master_ver2,
   input  wire logic                  alarm_active,
   input  wire logic [7:0]            alarm_code,
   input  wire logic                  alarm_strobe,
   output logic                       link_err_led,
   output logic                       device_reset,
   output logic [2:0]                 active_speed,
   output logic [3:0]                 active_factor,
   output logic                       active_ver2,
   output logic [6:0]                 active_station,
   output logic                       irq
);

   // ---------------------------------------------------------------
   // Reset terminal synchroniser
   // ---------------------------------------------------------------
   logic rst_meta, rst_sync, rst_prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
         rst_prev <= 1'b0;
      end else begin
         rst_meta <= reset_input_terminal;
         rst_sync <= rst_meta;
         rst_prev <= rst_sync;
      end
   end
   wire rst_rise = rst_sync & ~rst_prev;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Only the first access cycle acts, so a command fires once per transfer
   wire acc       = psel & penable & ~pready;
   wire wr        = acc & pwrite;
   wire rd        = acc & ~pwrite;
   wire hit_speed = (paddr == fslc_pkg::addr_speed);
   wire hit_occ   = (paddr == fslc_pkg::addr_occup);
   wire hit_stn   = (paddr == fslc_pkg::addr_station);
   wire hit_stat  = (paddr == fslc_pkg::addr_status);
   wire hit_cmd   = (paddr == fslc_pkg::addr_command);
   wire hit_ist   = (paddr == fslc_pkg::addr_irq_st);
   wire hit_msk   = (paddr == fslc_pkg::addr_irq_msk);
   wire hit_hist  = (paddr >= fslc_pkg::addr_hist) &&
                    (paddr < fslc_pkg::addr_hist + 12'(4 * fslc_pkg::hist_depth)) && (paddr[1:0] == 2'h0);
   wire mapped    = hit_speed | hit_occ | hit_stn | hit_stat | hit_cmd | hit_ist | hit_msk | hit_hist;

   function automatic logic occ_legal(input logic [4:0] v);
      occ_legal = (v == fslc_pkg::occ_compat) || (v == fslc_pkg::occ_single) ||
                  (v == fslc_pkg::occ_double) || (v == fslc_pkg::occ_quad) || (v == fslc_pkg::occ_oct);
   endfunction

   function automatic logic [3:0] occ_factor(input logic [4:0] v);
      case (v)
         fslc_pkg::occ_double: occ_factor = 4'(fslc_pkg::fslc_occ_x2);
         fslc_pkg::occ_quad:   occ_factor = 4'(fslc_pkg::fslc_occ_x4);
         fslc_pkg::occ_oct:    occ_factor = 4'(fslc_pkg::fslc_occ_x8);
         default:              occ_factor = 4'(fslc_pkg::fslc_occ_x1);
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Shadow and active configuration
   // ---------------------------------------------------------------
   fslc_pkg::fslc_cfg_type shadow, active;
   // Illegal values are refused so the shadow never holds a code the link cannot use
   wire speed_ok = wr & hit_speed & (pwdata[2:0] <= fslc_pkg::speed_max) & (pwdata[31:3] == '0);
   // A version-1 master cannot carry multi-station frames
   wire occ_ok   = wr & hit_occ & occ_legal(pwdata[4:0]) & (pwdata[31:5] == '0) &
                   (master_ver2 | (occ_factor(pwdata[4:0]) == 4'(fslc_pkg::fslc_occ_x1)));
   wire stn_ok   = wr & hit_stn & (pwdata[6:0] >= fslc_pkg::station_min) &
                   (pwdata[6:0] <= fslc_pkg::station_max) & (pwdata[31:7] == '0);
   wire bad_wr   = wr & ((hit_speed & ~speed_ok) | (hit_occ & ~occ_ok) | (hit_stn & ~stn_ok));

   // Error reset from the network only counts during a protective alarm
   wire err_rst  = wr & hit_cmd & pwdata[fslc_pkg::cmd_err_reset] & alarm_active;
   wire hist_clr = wr & hit_cmd & pwdata[fslc_pkg::cmd_hist_clear];
   wire refresh  = wr & hit_cmd & pwdata[fslc_pkg::cmd_refresh];
   wire apply    = rst_rise | err_rst;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow <= '{fslc_pkg::speed_rst, fslc_pkg::occ_compat, fslc_pkg::station_rst};
      end else begin
         if (speed_ok) shadow.speed   <= pwdata[2:0];
         if (occ_ok)   shadow.occup   <= pwdata[4:0];
         if (stn_ok)   shadow.station <= pwdata[6:0];
      end
   end

   // Power-up loads defaults; later changes wait here until a reset event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= '{fslc_pkg::speed_rst, fslc_pkg::occ_compat, fslc_pkg::station_rst};
      end else if (apply) begin
         active <= shadow;
      end
   end

   wire pending = (shadow != active);

   // ---------------------------------------------------------------
   // Configuration checks
   // ---------------------------------------------------------------
   sequence s_speed_bad_wr;
      acc & pwrite & hit_speed & (pwdata > 32'(fslc_pkg::speed_max));
   endsequence
   sequence s_occ_v1_wr;
      acc & pwrite & hit_occ & ~master_ver2 & (occ_factor(pwdata[4:0]) != 4'(fslc_pkg::fslc_occ_x1));
   endsequence
   sequence s_stn_bad_wr;
      acc & pwrite & hit_stn & ((pwdata == 32'h0) | (pwdata > 32'(fslc_pkg::station_max)));
   endsequence
   sequence s_err_cmd;
      acc & pwrite & hit_cmd & pwdata[fslc_pkg::cmd_err_reset];
   endsequence
   property p_speed_refuse;
      @(posedge pclk) disable iff (!presetn) s_speed_bad_wr |=> pslverr && $stable(shadow.speed);
   endproperty
   a_speed_refuse: assert property (p_speed_refuse) else $error("Refused speed value was stored");
   property p_occ_v1_refuse;
      @(posedge pclk) disable iff (!presetn) s_occ_v1_wr |=> pslverr && $stable(shadow.occup);
   endproperty
   a_occ_v1_refuse: assert property (p_occ_v1_refuse) else $error("Refused occupancy was stored");
   property p_stn_refuse;
      @(posedge pclk) disable iff (!presetn) s_stn_bad_wr |=> pslverr && $stable(shadow.station);
   endproperty
   a_stn_refuse: assert property (p_stn_refuse) else $error("Refused station number was stored");
   property p_active_hold;
      @(posedge pclk) disable iff (!presetn) !apply |=> $stable(active);
   endproperty
   a_active_hold: assert property (p_active_hold) else $error("Active setting changed unasked");
   property p_active_load;
      @(posedge pclk) disable iff (!presetn) apply |=> device_reset && (active == $past(shadow));
   endproperty
   a_active_load: assert property (p_active_load) else $error("Reset did not load the shadow");
   property p_err_ignored;
      @(posedge pclk) disable iff (!presetn) s_err_cmd ##0 !alarm_active ##0 !rst_rise |=> !device_reset;
   endproperty
   a_err_ignored: assert property (p_err_ignored) else $error("Error reset acted without an alarm");
   property p_err_taken;
      @(posedge pclk) disable iff (!presetn) s_err_cmd ##0 alarm_active |=> device_reset;
   endproperty
   a_err_taken: assert property (p_err_taken) else $error("Error reset ignored during an alarm");

   // ---------------------------------------------------------------
   // Lamp flicker divider
   // ---------------------------------------------------------------
   logic [31:0] flick_cnt;
   wire flick_tick = (flick_cnt == 32'(flicker_period - 1));

   sequence s_flick;
      pending & flick_tick;
   endsequence
   property p_led_flicker;
      @(posedge pclk) disable iff (!presetn) s_flick |=> link_err_led != $past(link_err_led);
   endproperty
   a_led_flicker: assert property (p_led_flicker) else $error("Error lamp missed a flicker step");
   property p_led_dark;
      @(posedge pclk) disable iff (!presetn) !pending |=> !link_err_led;
   endproperty
   a_led_dark: assert property (p_led_dark) else $error("Error lamp lit with nothing pending");

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flick_cnt    <= '0;
         link_err_led <= 1'b0;
      end else if (!pending) begin
         flick_cnt    <= '0;
         link_err_led <= 1'b0;
      end else begin
         flick_cnt    <= flick_tick ? '0 : flick_cnt + 32'h1;
         if (flick_tick) link_err_led <= ~link_err_led;
      end
   end

   // ---------------------------------------------------------------
   // Refresh supervision
   // ---------------------------------------------------------------
   // Only the upper bound is policed; a fast master is always legal
   logic [31:0] ref_cnt;
   logic        ref_seen;
   wire ref_late = ref_seen & (ref_cnt == 32'(refresh_timeout));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt  <= '0;
         ref_seen <= 1'b0;
      end else if (refresh) begin
         ref_cnt  <= '0;
         ref_seen <= 1'b1;
      end else if (ref_late) begin
         ref_seen <= 1'b0;
      end else if (ref_seen) begin
         ref_cnt  <= ref_cnt + 32'h1;
      end
   end

   // ---------------------------------------------------------------
   // Alarm history
   // ---------------------------------------------------------------
   logic [7:0] hist [fslc_pkg::hist_depth];
   property p_hist_clear;
      @(posedge pclk) disable iff (!presetn) hist_clr |=> (hist[0] == 8'h00) && (hist[fslc_pkg::hist_depth-1] == 8'h00);
   endproperty
   a_hist_clear: assert property (p_hist_clear) else $error("Alarm history not erased");
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < fslc_pkg::hist_depth; i++) hist[i] <= 8'h00;
      end else if (hist_clr) begin
         for (int i = 0; i < fslc_pkg::hist_depth; i++) hist[i] <= 8'h00;
      end else if (alarm_strobe) begin
         hist[0] <= alarm_code;
         for (int i = 1; i < fslc_pkg::hist_depth; i++) hist[i] <= hist[i-1];
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   logic [fslc_pkg::irq_width-1:0] irq_st, irq_msk;
   wire [fslc_pkg::irq_width-1:0] irq_ev = {ref_late, hist_clr, err_rst, pending & ~flick_cnt[0] & (flick_cnt == '0)};
   wire ist_rd = rd & hit_ist;
   property p_refresh_late;
      @(posedge pclk) disable iff (!presetn) ref_late & ~refresh |=> !ref_seen && irq_st[fslc_pkg::irq_refresh_to];
   endproperty
   a_refresh_late: assert property (p_refresh_late) else $error("Late refresh not flagged");
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st  <= '0;
         irq_msk <= '0;
         irq     <= 1'b0;
      end else begin
         // A new event in the clearing read cycle survives
         irq_st  <= (ist_rd ? '0 : irq_st) | irq_ev;
         if (wr & hit_msk) irq_msk <= pwdata[fslc_pkg::irq_width-1:0];
         irq     <= |(((ist_rd ? '0 : irq_st) | irq_ev) & irq_msk);
      end
   end

   // ---------------------------------------------------------------
   // Read data and registered outputs
   // ---------------------------------------------------------------
   wire [2:0]  hidx   = 3'((paddr - fslc_pkg::addr_hist) >> 2);
   wire [31:0] status = {22'h0, alarm_active, master_ver2, ref_seen, pending, occ_factor(active.occup),
                         2'h0};
   wire [31:0] rmux   = hit_speed ? {29'h0, shadow.speed} :
                        hit_occ   ? {27'h0, shadow.occup} :
                        hit_stn   ? {25'h0, shadow.station} :
                        hit_stat  ? status :
                        hit_ist   ? 32'(irq_st) :
                        hit_msk   ? 32'(irq_msk) :
                        hit_hist  ? {24'h0, hist[hidx]} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata         <= 32'h0;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         device_reset   <= 1'b0;
         active_speed   <= fslc_pkg::speed_rst;
         active_factor  <= 4'(fslc_pkg::fslc_occ_x1);
         active_ver2    <= 1'b0;
         active_station <= fslc_pkg::station_rst;
      end else begin
         // One wait state: ready rises at the end of the first access cycle, falls after
         pready         <= psel & penable & ~pready;
         pslverr        <= psel & penable & ~pready & (~mapped | bad_wr);
         prdata         <= (psel & penable & ~pready & ~pwrite) ? rmux : 32'h0;
         device_reset   <= apply;
         active_speed   <= active.speed;
         active_factor  <= occ_factor(active.occup);
         active_ver2    <= occ_factor(active.occup) != 4'(fslc_pkg::fslc_occ_x1);
         active_station <= active.station;
      end
   end

   // One wait state, then ready drops again
   sequence s_access;
      acc;
   endsequence
   property p_ready_once;
      @(posedge pclk) disable iff (!presetn) s_access |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("Bus answer not one cycle after access");

endmodule // fslc_link_config

// ==== core/fslc_pkg.sv ====
package fslc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] addr_speed   = 12'h000;
   localparam logic [11:0] addr_occup   = 12'h004;
   localparam logic [11:0] addr_station = 12'h008;
   localparam logic [11:0] addr_status  = 12'h00c;
   localparam logic [11:0] addr_command = 12'h010;
   localparam logic [11:0] addr_irq_st  = 12'h014;
   localparam logic [11:0] addr_irq_msk = 12'h018;
   localparam logic [11:0] addr_hist    = 12'h01c;

   // ---------------------------------------------------------------
   // Field values and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] speed_max       = 3'h4;
   localparam logic [2:0] speed_rst       = 3'h0;
   localparam logic [4:0] occ_compat      = 5'h00;
   localparam logic [4:0] occ_single      = 5'h01;
   localparam logic [4:0] occ_double      = 5'h0c;
   localparam logic [4:0] occ_quad        = 5'h0e;
   localparam logic [4:0] occ_oct         = 5'h12;
   localparam logic [6:0] station_min     = 7'h01;
   localparam logic [6:0] station_max     = 7'h40;
   localparam logic [6:0] station_rst     = 7'h01;
   localparam int         hist_depth      = 8;
   localparam int         cmd_err_reset   = 0;
   localparam int         cmd_hist_clear  = 1;
   localparam int         cmd_refresh     = 2;
   localparam int         irq_pending     = 0;
   localparam int         irq_err_reset   = 1;
   localparam int         irq_hist_clear  = 2;
   localparam int         irq_refresh_to  = 3;
   localparam int         irq_width       = 4;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int clk_hz           = 20000000;
   localparam int refresh_max_us   = 141000;
   localparam int refresh_max_cyc  = (refresh_max_us / 1000) * (clk_hz / 1000);
   localparam int flicker_ms       = 250;
   localparam int flicker_cyc      = flicker_ms * (clk_hz / 1000);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      fslc_rate_156k = 3'h0,
      fslc_rate_625k = 3'h1,
      fslc_rate_2m5  = 3'h2,
      fslc_rate_5m   = 3'h3,
      fslc_rate_10m  = 3'h4
   } fslc_rate_type;

   typedef enum logic [3:0] {
      fslc_occ_x1 = 4'h1,
      fslc_occ_x2 = 4'h2,
      fslc_occ_x4 = 4'h4,
      fslc_occ_x8 = 4'h8
   } fslc_occ_type;

   typedef struct packed {
      logic [2:0] speed;
      logic [4:0] occup;
      logic [6:0] station;
   } fslc_cfg_type;

endpackage

// ==== tb/fslc_master_model.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Master station side: capability level and alarm events
// ---------------------------------------------------------------
module fslc_master_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ver2_cap,
   input  wire logic       alarm_on,
   input  wire logic       push,
   input  wire logic [7:0] code,
   output logic            master_ver2,
   output logic            alarm_active,
   output logic [7:0]      alarm_code,
   output logic            alarm_strobe
);
   logic push_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_ver2  <= 1'b0;
         alarm_active <= 1'b0;
         push_d       <= 1'b0;
         alarm_strobe <= 1'b0;
         alarm_code   <= 8'h00;
      end else begin
         master_ver2  <= ver2_cap;
         alarm_active <= alarm_on;
         push_d       <= push;
         alarm_strobe <= push & ~push_d;
         // Code is only valid with the strobe, so it churns otherwise
         alarm_code   <= (push & ~push_d) ? code : ~alarm_code;
      end
   end
endmodule // fslc_master_model

// ==== tb/fslc_link_config_tb_top.sv ====
`timescale 1ns/10ps
module fslc_link_config_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_pin, ver2_cap, alarm_on, push;
   logic        link_err_led, device_reset, active_ver2, irq, master_ver2, alarm_active, alarm_strobe, er, led_hi;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  code, alarm_code;
   logic [2:0]  active_speed;
   logic [3:0]  active_factor;
   logic [6:0]  active_station;
   int          mismatches, num_checks, dr_cnt;
   logic [4:0]  occ_val [5] = '{fslc_pkg::occ_double, fslc_pkg::occ_quad, fslc_pkg::occ_oct,
                                fslc_pkg::occ_single, fslc_pkg::occ_compat};
   logic [3:0]  occ_fac [5] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h1}; // Expected active_factor for each occupancy value in occ_val

   // Short counts keep the flicker visible within a few cycles
   fslc_link_config #(.refresh_timeout(50), .flicker_period(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_input_terminal(rst_pin),
      .master_ver2(master_ver2), .alarm_active(alarm_active), .alarm_code(alarm_code),
      .alarm_strobe(alarm_strobe), .link_err_led(link_err_led), .device_reset(device_reset),
      .active_speed(active_speed), .active_factor(active_factor), .active_ver2(active_ver2),
      .active_station(active_station), .irq(irq));
   fslc_master_model master_u (
      .pclk(pclk), .presetn(presetn), .ver2_cap(ver2_cap), .alarm_on(alarm_on), .push(push), .code(code),
      .master_ver2(master_ver2), .alarm_active(alarm_active), .alarm_code(alarm_code),
      .alarm_strobe(alarm_strobe));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Sampled on the falling edge so counting never races the tasks
   always @(negedge pclk) begin
      if (device_reset === 1'b1) dr_cnt++;
      if (link_err_led === 1'b1) led_hi = 1'b1;
   end
   task end_sim;
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk(n, 2);
   endtask
   task pin_reset;
      int c0;
      c0 = dr_cnt;
      rst_pin <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(dr_cnt, c0 + 1);
      rst_pin <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task push_alarm(input logic [7:0] c);
      @(posedge pclk);
      push <= 1'b1;
      code <= c;
      @(posedge pclk);
      push <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_defaults;
      chk(active_speed, 3'h0);
      chk(active_factor, 4'h1);
      chk(active_station, 7'h01);
      chk(link_err_led, 1'b0);
      apb(1'b0, fslc_pkg::addr_station, 32'h0);
      chk(rd, 32'h1);
   endtask
   task t_speed;
      for (int v = 1; v <= 4; v++) begin
         led_hi = 1'b0;
         apb(1'b1, fslc_pkg::addr_speed, v);
         chk(er, 1'b0);
         repeat (12) @(posedge pclk);
         chk(led_hi, 1'b1);
         chk(active_speed, v - 1);
         pin_reset;
         chk(active_speed, v);
         chk(link_err_led, 1'b0);
      end
      apb(1'b1, fslc_pkg::addr_speed, 32'h5);
      chk(er, 1'b1);
   endtask
   task t_occ;
      logic [3:0] fo;
      fo = 4'h1;
      apb(1'b1, fslc_pkg::addr_occup, 32'hc);
      chk(er, 1'b1);
      ver2_cap <= 1'b1;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, fslc_pkg::addr_occup, occ_val[i]);
         chk(er, 1'b0);
         chk(active_factor, fo);
         pin_reset;
         chk(active_factor, occ_fac[i]);
         chk(active_ver2, occ_fac[i] != 4'h1);
         fo = occ_fac[i];
      end
      apb(1'b1, fslc_pkg::addr_occup, 32'h3);
      chk(er, 1'b1);
   endtask
   task t_station;
      apb(1'b1, fslc_pkg::addr_station, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, fslc_pkg::addr_station, 32'h41);
      chk(er, 1'b1);
      apb(1'b1, fslc_pkg::addr_station, 32'h40);
      chk(active_station, 7'h01);
      pin_reset;
      chk(active_station, 7'h40);
   endtask
   task t_errrst;
      int c0;
      apb(1'b1, fslc_pkg::addr_speed, 32'h2);
      c0 = dr_cnt;
      apb(1'b1, fslc_pkg::addr_command, 32'h1);
      repeat (12) @(posedge pclk);
      chk(dr_cnt, c0);
      chk(active_speed, 3'h4);
      apb(1'b1, fslc_pkg::addr_irq_msk, 32'h2);
      alarm_on <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b1, fslc_pkg::addr_command, 32'h1);
      repeat (12) @(posedge pclk);
      chk(dr_cnt, c0 + 1);
      chk(active_speed, 3'h2);
      chk(irq, 1'b1);
      apb(1'b0, fslc_pkg::addr_irq_st, 32'h0);
      chk(rd[1], 1'b1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      alarm_on <= 1'b0;
   endtask
   task t_hist;
      for (int i = 1; i <= 9; i++) push_alarm(i);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'(fslc_pkg::addr_hist + 4 * i), 32'h0);
         chk(rd, 9 - i);
      end
      apb(1'b1, fslc_pkg::addr_command, 32'h2);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'(fslc_pkg::addr_hist + 4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      chk(irq, 1'b0);
      apb(1'b0, fslc_pkg::addr_irq_st, 32'h0);
      chk(rd[2], 1'b1);
      apb(1'b0, 12'h100, 32'h0);
      chk(er, 1'b1);
   endtask

   task t_refresh;
      apb(1'b1, fslc_pkg::addr_irq_msk, 32'h8);
      // Refresh marks come well inside the limit
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, fslc_pkg::addr_command, 32'h4);
         repeat (20) @(posedge pclk);
      end
      apb(1'b0, fslc_pkg::addr_irq_st, 32'h0);
      chk(rd[3], 1'b0);
      chk(irq, 1'b0);
      apb(1'b0, fslc_pkg::addr_status, 32'h0);
      chk(rd[9:2], 8'h61);
      repeat (60) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b0, fslc_pkg::addr_status, 32'h0);
      chk(rd[7], 1'b0);
      apb(1'b0, fslc_pkg::addr_irq_st, 32'h0);
      chk(rd[3], 1'b1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, rst_pin, ver2_cap, alarm_on, push, led_hi} <= '0;
      {paddr, pwdata, code} <= '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults;
      t_speed;
      t_occ;
      t_station;
      t_errrst;
      t_hist;
      t_refresh;
      end_sim;
   end
   initial begin
      repeat (6000) @(posedge pclk);
      mismatches++;
      end_sim;
   end
endmodule // fslc_link_config_tb_top
